/* File: rtl/nvsi_pkg.sv */
package nvsi_pkg;

  // Clock and timebase
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned MS_CYCLES      = CLK_HZ / 1000;

  // Host register map
  localparam logic [7:0]  USER_IND_OFFSET = 8'h10;
  localparam logic [7:0]  USER_IND_ON     = 8'h01;
  localparam logic [7:0]  USER_IND_OFF    = 8'h00;
  localparam logic [7:0]  USER_IND_RESET  = 8'h00;
  localparam logic [7:0]  UNMAPPED_RDATA  = 8'h00;

  // Activity indicator pattern, in milliseconds
  localparam int unsigned FAST_ON_MS     = 100;
  localparam int unsigned FAST_OFF_MS    = 200;
  localparam int unsigned FAST_PERIOD_MS = FAST_ON_MS + FAST_OFF_MS;
  localparam int unsigned SLOW_PERIOD_S  = 15;
  localparam int unsigned SLOW_PERIOD_MS = SLOW_PERIOD_S * 1000;
  localparam int unsigned SLOW_ON_MS     = 100;
  localparam int unsigned BLINK_CW       = 14;

  // Energy module link: 100 kHz bit rate, four phases a bit
  localparam int unsigned SMB_QTR_NS     = 2500;
  localparam int unsigned SMB_QTR_CYCLES =
    (SMB_QTR_NS * (CLK_HZ / 1_000_000)) / 1000;

  // Link sequencer states
  typedef enum logic [2:0] {
    SMB_IDLE,
    SMB_START,
    SMB_SEND,
    SMB_RACK,
    SMB_RECV,
    SMB_MNACK,
    SMB_STOP
  } nvsi_smb_e;

endpackage : nvsi_pkg

/* File: rtl/nvsi_blink_if.sv */
`timescale 1ns/10ps
interface nvsi_blink_if;
  logic ms_tick;
  logic fast;
  logic slow;
  logic restart;
  logic user_indicator_control;

  modport ctrl  (output ms_tick, output fast, output slow, output restart,
                 input user_indicator_control);
  modport blink (input ms_tick, input fast, input slow, input restart,
                 output user_indicator_control);
endinterface : nvsi_blink_if

/* File: rtl/nvsi_divider.sv */
`timescale 1ns/10ps
module nvsi_divider #(
  parameter int unsigned DIV = 25000
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } nvsi_div_s;

  nvsi_div_s s_q;
  nvsi_div_s s_d;

  generate
    if (DIV < 2) begin : g_bad_div
      $error("nvsi_divider needs DIV of two or more");
    end
  endgenerate

  // Free running count, one-cycle tick on wrap
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == LAST) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;
endmodule : nvsi_divider

/* File: rtl/nvsi_blink.sv */
`timescale 1ns/10ps
module nvsi_blink
  import nvsi_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  nvsi_blink_if.blink bl
);
  typedef struct packed {
    logic [BLINK_CW-1:0] ms;
    logic                user_indicator_control;
  } nvsi_blink_s;

  nvsi_blink_s s_q;
  nvsi_blink_s s_d;

  // Millisecond phase counter; fast pattern takes priority over slow
  always_comb begin
    s_d = s_q;
    if (bl.restart) begin
      s_d.ms = '0;
    end else if (bl.ms_tick) begin
      if (bl.fast && s_q.ms >= BLINK_CW'(FAST_PERIOD_MS - 1)) begin
        s_d.ms = '0;
      end else if (s_q.ms >= BLINK_CW'(SLOW_PERIOD_MS - 1)) begin
        s_d.ms = '0;
      end else begin
        s_d.ms = s_q.ms + BLINK_CW'(1);
      end
    end
    if (bl.fast) begin
      s_d.user_indicator_control = (s_d.ms < BLINK_CW'(FAST_ON_MS));
    end else if (bl.slow) begin
      s_d.user_indicator_control = (s_d.ms < BLINK_CW'(SLOW_ON_MS));
    end else begin
      s_d.user_indicator_control = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bl.user_indicator_control = s_q.user_indicator_control;
endmodule : nvsi_blink

/* File: rtl/nvsi_top.sv */
`timescale 1ns/10ps
module nvsi_top
  import nvsi_pkg::*;
#(
  parameter int unsigned MS_DIV  = MS_CYCLES,
  parameter int unsigned QTR_DIV = SMB_QTR_CYCLES
) (
  input  wire logic       CORE_CLK_I,
  input  wire logic       RESET_I,
  // Host register port
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic       REG_WE_I,
  input  wire logic       REG_RE_I,
  input  wire logic [7:0] REG_WDATA_I,
  output logic      [7:0] REG_RDATA_O,
  output logic            REG_RVALID_O,
  // Controller status
  input  wire logic       BACKUP_ACTIVE_I,
  input  wire logic       RESTORE_ACTIVE_I,
  input  wire logic       FW_READY_I,
  output logic            POWER_INDICATOR_O,
  output logic            ACTIVITY_INDICATOR_O,
  output logic            USER_INDICATOR_O,
  output logic            DRAM_SLOW_CLK_SEL_O,
  // Energy module sideband
  input  wire logic       EM_DISCHARGE_REQ_I,
  input  wire logic       EM_DETECT_I,
  output logic            EM_DETECT_O,
  output logic            EM_DETECT_OE_O,
  output logic            EM_PRESENT_O,
  input  wire logic       EM_POWER_FAIL_N_I,
  input  wire logic       PFAIL_TRIG_EN_I,
  output logic            BACKUP_TRIG_O,
  // Energy module link command port
  input  wire logic       SMB_START_I,
  input  wire logic [6:0] SMB_ADDR_I,
  input  wire logic       SMB_READ_I,
  input  wire logic [7:0] SMB_WDATA_I,
  output logic            SMB_BUSY_O,
  output logic            SMB_DONE_O,
  output logic            SMB_NACK_O,
  output logic      [7:0] SMB_RDATA_O,
  // Energy module link pins
  output logic            ENERGY_MODULE_SMB_CLOCK_O,
  input  wire logic       ENERGY_MODULE_SMB_DATA_I,
  output logic            ENERGY_MODULE_SMB_DATA_O,
  output logic            ENERGY_MODULE_SMB_DATA_OE_O
);

  typedef struct packed {
    nvsi_smb_e  st;
    logic [1:0] ph;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic       second;
    logic       rd;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic       nack;
    logic       done;
    logic       scl;
    logic       sda_low;
    logic [7:0] user_reg;
    logic       user_led;
    logic [7:0] rdata;
    logic       rvalid;
    logic       pwr;
    logic       dis_oe;
    logic       present;
    logic       pf_prev;
    logic       trig;
    logic       op_prev;
    logic       slow_dram;
  } nvsi_state_s;

  localparam nvsi_state_s RESET_STATE = '{
    st:        SMB_IDLE,
    ph:        2'h0,
    bitn:      3'h7,
    sh:        8'h00,
    second:    1'b0,
    rd:        1'b0,
    wdat:      8'h00,
    rdat:      8'h00,
    nack:      1'b0,
    done:      1'b0,
    scl:       1'b1,
    sda_low:   1'b0,
    user_reg:  USER_IND_RESET,
    user_led:  1'b0,
    rdata:     8'h00,
    rvalid:    1'b0,
    pwr:       1'b1,
    dis_oe:    1'b0,
    present:   1'b0,
    pf_prev:   1'b1,
    trig:      1'b0,
    op_prev:   1'b0,
    slow_dram: 1'b0
  };

  nvsi_state_s  s_q;
  nvsi_state_s  s_d;
  logic         qtick;
  logic         op_active;
  logic [1:0]   np;
  nvsi_blink_if bl ();

  // Address decode shared by the read and write paths
  function automatic logic user_hit(input logic [7:0] addr);
    user_hit = (addr == USER_IND_OFFSET);
  endfunction : user_hit

  generate
    if (MS_DIV < 2 || QTR_DIV < 2) begin : g_bad_div
      $error("nvsi_top dividers need two or more cycles");
    end
  endgenerate

  // Timebases: one for the activity indicator, one for link bit phases
  nvsi_divider #(.DIV(MS_DIV)) u_ms_div (
    .clk_i  (CORE_CLK_I),
    .rst_i  (RESET_I),
    .tick_o (bl.ms_tick)
  );

  nvsi_divider #(.DIV(QTR_DIV)) u_qtr_div (
    .clk_i  (CORE_CLK_I),
    .rst_i  (RESET_I),
    .tick_o (qtick)
  );

  // Activity pattern; restart on each change of operation state
  assign op_active  = BACKUP_ACTIVE_I | RESTORE_ACTIVE_I;
  assign bl.fast    = op_active;
  assign bl.slow    = FW_READY_I;
  assign bl.restart = op_active ^ s_q.op_prev;

  nvsi_blink u_blink (
    .clk_i (CORE_CLK_I),
    .rst_i (RESET_I),
    .bl    (bl)
  );

  assign np = s_q.ph + 2'h1;

  // Registers, sideband pins and link sequencer
  always_comb begin
    s_d        = s_q;
    s_d.done   = 1'b0;
    s_d.rvalid = 1'b0;
    s_d.trig   = 1'b0;
    s_d.pwr    = 1'b1;

    // Host register: only exact 0x01 lights the lamp
    if (REG_WE_I && user_hit(REG_ADDR_I)) begin
      s_d.user_reg = REG_WDATA_I;
    end
    s_d.user_led = (s_q.user_reg == USER_IND_ON);
    if (REG_RE_I) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = user_hit(REG_ADDR_I) ? s_q.user_reg
                                        : UNMAPPED_RDATA;
    end

    // Presence is only judged while the line was released
    s_d.dis_oe = EM_DISCHARGE_REQ_I;
    if (!s_q.dis_oe) begin
      s_d.present = ~EM_DETECT_I;
    end

    // Falling power-fail edge starts a backup when enabled
    s_d.pf_prev = EM_POWER_FAIL_N_I;
    s_d.trig    = PFAIL_TRIG_EN_I & s_q.pf_prev & ~EM_POWER_FAIL_N_I;

    s_d.op_prev   = op_active;
    s_d.slow_dram = op_active;

    // Link: four phases a bit, clock high in phases two and three
    unique case (s_q.st)
      SMB_IDLE: begin
        s_d.scl     = 1'b1;
        s_d.sda_low = 1'b0;
        if (SMB_START_I) begin
          s_d.st     = SMB_START;
          s_d.ph     = 2'h0;
          s_d.sh     = {SMB_ADDR_I, SMB_READ_I};
          s_d.rd     = SMB_READ_I;
          s_d.wdat   = SMB_WDATA_I;
          s_d.second = 1'b0;
          s_d.nack   = 1'b0;
          s_d.bitn   = 3'h7;
        end
      end
      SMB_START: if (qtick) begin
        s_d.ph  = np;
        s_d.scl = (np != 2'h0);
        if (np == 2'h2) begin
          s_d.sda_low = 1'b1;
        end
        if (np == 2'h0) begin
          s_d.st = SMB_SEND;
        end
      end
      SMB_SEND: if (qtick) begin
        s_d.ph  = np;
        s_d.scl = np[1];
        if (np == 2'h1) begin
          s_d.sda_low = ~s_q.sh[7];
        end
        if (np == 2'h0) begin
          s_d.sh = {s_q.sh[6:0], 1'b0};
          if (s_q.bitn == 3'h0) begin
            s_d.st = SMB_RACK;
          end else begin
            s_d.bitn = s_q.bitn - 3'h1;
          end
        end
      end
      SMB_RACK: if (qtick) begin
        s_d.ph  = np;
        s_d.scl = np[1];
        if (np == 2'h1) begin
          s_d.sda_low = 1'b0;
        end
        if (np == 2'h3) begin
          s_d.nack = ENERGY_MODULE_SMB_DATA_I;
        end
        if (np == 2'h0) begin
          s_d.bitn = 3'h7;
          if (s_q.nack || s_q.second) begin
            s_d.st = SMB_STOP;
          end else begin
            s_d.second = 1'b1;
            s_d.sh     = s_q.wdat;
            s_d.st     = s_q.rd ? SMB_RECV : SMB_SEND;
          end
        end
      end
      SMB_RECV: if (qtick) begin
        s_d.ph  = np;
        s_d.scl = np[1];
        if (np == 2'h1) begin
          s_d.sda_low = 1'b0;
        end
        if (np == 2'h3) begin
          s_d.rdat = {s_q.rdat[6:0], ENERGY_MODULE_SMB_DATA_I};
        end
        if (np == 2'h0) begin
          if (s_q.bitn == 3'h0) begin
            s_d.st = SMB_MNACK;
          end else begin
            s_d.bitn = s_q.bitn - 3'h1;
          end
        end
      end
      SMB_MNACK: if (qtick) begin
        // Master leaves data released: last byte of a read
        s_d.ph  = np;
        s_d.scl = np[1];
        if (np == 2'h1) begin
          s_d.sda_low = 1'b0;
        end
        if (np == 2'h0) begin
          s_d.st = SMB_STOP;
        end
      end
      SMB_STOP: if (qtick) begin
        s_d.ph  = np;
        s_d.scl = np[1];
        if (np == 2'h1) begin
          s_d.sda_low = 1'b1;
        end
        if (np == 2'h3) begin
          s_d.sda_low = 1'b0; // Rising data with clock high
        end
        if (np == 2'h0) begin
          s_d.scl  = 1'b1;
          s_d.st   = SMB_IDLE;
          s_d.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // Indicators and status
  assign POWER_INDICATOR_O    = s_q.pwr;
  assign ACTIVITY_INDICATOR_O = bl.user_indicator_control;
  assign USER_INDICATOR_O     = s_q.user_led;
  assign DRAM_SLOW_CLK_SEL_O  = s_q.slow_dram;
  assign REG_RDATA_O          = s_q.rdata;
  assign REG_RVALID_O         = s_q.rvalid;

  // Open-drain lines only ever pull low
  assign EM_DETECT_O          = 1'b0;
  assign EM_DETECT_OE_O       = s_q.dis_oe;
  assign EM_PRESENT_O         = s_q.present;
  assign BACKUP_TRIG_O        = s_q.trig;

  // Link; clock is push-pull, no stretching by the slave
  assign SMB_BUSY_O                  = (s_q.st != SMB_IDLE);
  assign SMB_DONE_O                  = s_q.done;
  assign SMB_NACK_O                  = s_q.nack;
  assign SMB_RDATA_O                 = s_q.rdat;
  assign ENERGY_MODULE_SMB_CLOCK_O   = s_q.scl;
  assign ENERGY_MODULE_SMB_DATA_O    = 1'b0;
  assign ENERGY_MODULE_SMB_DATA_OE_O = s_q.sda_low;

endmodule : nvsi_top

/* File: testbench/nvsi_sva.sv */
`timescale 1ns/10ps
module nvsi_sva
  import nvsi_pkg::*;
#(
  parameter int unsigned MS_DIV = MS_CYCLES
) (
  input wire logic       CORE_CLK_I,
  input wire logic       RESET_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic       REG_WE_I,
  input wire logic       REG_RE_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic       REG_RVALID_O,
  input wire logic       BACKUP_ACTIVE_I,
  input wire logic       RESTORE_ACTIVE_I,
  input wire logic       POWER_INDICATOR_O,
  input wire logic       ACTIVITY_INDICATOR_O,
  input wire logic       USER_INDICATOR_O,
  input wire logic       DRAM_SLOW_CLK_SEL_O,
  input wire logic       EM_DISCHARGE_REQ_I,
  input wire logic       EM_DETECT_I,
  input wire logic       EM_DETECT_O,
  input wire logic       EM_DETECT_OE_O,
  input wire logic       EM_PRESENT_O,
  input wire logic       EM_POWER_FAIL_N_I,
  input wire logic       PFAIL_TRIG_EN_I,
  input wire logic       BACKUP_TRIG_O,
  input wire logic       SMB_START_I,
  input wire logic       SMB_BUSY_O,
  input wire logic       SMB_DONE_O
);
  localparam int DONE_MAX = 400;
  int unsigned on_run_q;

  // Length of the current lit stretch of the activity lamp
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I || !ACTIVITY_INDICATOR_O)
      on_run_q <= 0;
    else
      on_run_q <= on_run_q + 1;
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);

  // Link request taken, and a power drop while enabled
  sequence s_take;
    SMB_START_I && !SMB_BUSY_O;
  endsequence
  sequence s_drop;
    $fell(EM_POWER_FAIL_N_I) && PFAIL_TRIG_EN_I;
  endsequence

  a_power_lit: assert property (POWER_INDICATOR_O)
    else $error("power lamp dark");
  a_lamp_on_len: assert property (on_run_q <= FAST_ON_MS * MS_DIV)
    else $error("activity lamp lit too long");
  a_user_lamp: assert property (
    REG_WE_I && REG_ADDR_I == USER_IND_OFFSET |-> ##2
    USER_INDICATOR_O == ($past(REG_WDATA_I, 2) == USER_IND_ON))
    else $error("user lamp disagrees with write");
  a_read_answer: assert property (REG_RE_I |=> REG_RVALID_O)
    else $error("read not answered");
  a_no_answer: assert property (!REG_RE_I |=> !REG_RVALID_O)
    else $error("answer without read");
  a_slow_sel: assert property (
    (BACKUP_ACTIVE_I || RESTORE_ACTIVE_I) |=> DRAM_SLOW_CLK_SEL_O)
    else $error("slow dram clock not selected");
  a_discharge_drive: assert property (
    EM_DISCHARGE_REQ_I |=> EM_DETECT_OE_O && !EM_DETECT_O)
    else $error("discharge not driven");
  a_present_sense: assert property (
    !EM_DETECT_OE_O |=> EM_PRESENT_O == !$past(EM_DETECT_I))
    else $error("presence misread");
  a_trig_pulse: assert property (
    s_drop |=> BACKUP_TRIG_O ##1 !BACKUP_TRIG_O)
    else $error("backup trigger missing");
  a_link_done: assert property (s_take |-> ##[1:DONE_MAX] SMB_DONE_O)
    else $error("link transfer never done");
endmodule : nvsi_sva

bind nvsi_top nvsi_sva #(.MS_DIV(MS_DIV)) u_sva (
  .CORE_CLK_I, .RESET_I, .REG_ADDR_I, .REG_WE_I, .REG_RE_I, .REG_WDATA_I,
  .REG_RVALID_O, .BACKUP_ACTIVE_I, .RESTORE_ACTIVE_I, .POWER_INDICATOR_O,
  .ACTIVITY_INDICATOR_O, .USER_INDICATOR_O, .DRAM_SLOW_CLK_SEL_O,
  .EM_DISCHARGE_REQ_I, .EM_DETECT_I, .EM_DETECT_O, .EM_DETECT_OE_O,
  .EM_PRESENT_O, .EM_POWER_FAIL_N_I, .PFAIL_TRIG_EN_I, .BACKUP_TRIG_O,
  .SMB_START_I, .SMB_BUSY_O, .SMB_DONE_O);

/* File: testbench/nvsi_em_model.sv */
`timescale 1ns/10ps
module nvsi_em_model #(
  parameter logic [6:0] SLV_ADDR = 7'h0B,
  parameter logic [7:0] RD_BYTE  = 8'hA5
) (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_oe_o,
  output logic      [7:0] wr_byte_o
);
  int         bit_n = 0;
  logic       act   = 1'b0;
  logic [7:0] hdr   = 8'h00;

  initial sda_oe_o = 1'b0;
  initial wr_byte_o = 8'h00;

  // Start and stop: data moves while the clock is high
  always @(negedge sda_i) if (scl_i) begin
    act = 1'b1;
    bit_n = 0;
  end
  always @(posedge sda_i) if (scl_i) act = 1'b0;

  // Sample on clock rise
  always @(posedge scl_i) if (act) begin
    bit_n++;
    if (bit_n <= 8)
      hdr = {hdr[6:0], sda_i};
    else if (bit_n >= 10 && bit_n <= 17 && !hdr[0])
      wr_byte_o = {wr_byte_o[6:0], sda_i};
  end

  // Change drive only on clock fall; no stretching, released otherwise
  always @(negedge scl_i) begin
    if (!act)
      sda_oe_o = 1'b0;
    else if (bit_n == 8)
      sda_oe_o = (hdr[7:1] == SLV_ADDR);
    else if (bit_n == 17)
      sda_oe_o = !hdr[0];
    else if (hdr[0] && hdr[7:1] == SLV_ADDR && bit_n >= 9 && bit_n <= 16)
      sda_oe_o = !RD_BYTE[16 - bit_n];
    else
      sda_oe_o = 1'b0;
  end
endmodule : nvsi_em_model

/* File: testbench/nvsi_tb_top.sv */
`timescale 1ns/10ps
module nvsi_tb_top
  import nvsi_pkg::*;
;
  localparam logic [6:0] EM_ADDR = 7'h0B;
  localparam logic [7:0] EM_BYTE = 8'hA5;
  logic       clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, s_wd = 8'h00, s_rdata;
  logic [7:0] em_wr;
  logic       bk = 1'b0, rs = 1'b0, fw = 1'b0, dis = 1'b0, pf_n = 1'b1;
  logic       pf_en = 1'b0, s_go = 1'b0, s_rd = 1'b0, em_here = 1'b0;
  logic [6:0] s_addr = 7'h00;
  logic       rvalid, pwr, act, usr, slowsel, det_o, det_oe, pres, trig;
  logic       s_busy, s_done, s_nack, scl, sda_o, sda_oe, em_oe;
  wire        det = !(det_oe || em_here);
  wire        sda = !(sda_oe || em_oe);
  int         bad_count = 0, cmp_count = 0, cycles = 0, trig_seen = 0;
  int         c;

  always #20 clk = !clk;

  nvsi_top #(.MS_DIV(4), .QTR_DIV(2)) i_dut (
    .CORE_CLK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WE_I(we),
    .REG_RE_I(re), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .BACKUP_ACTIVE_I(bk), .RESTORE_ACTIVE_I(rs),
    .FW_READY_I(fw), .POWER_INDICATOR_O(pwr), .ACTIVITY_INDICATOR_O(act),
    .USER_INDICATOR_O(usr), .DRAM_SLOW_CLK_SEL_O(slowsel),
    .EM_DISCHARGE_REQ_I(dis), .EM_DETECT_I(det), .EM_DETECT_O(det_o),
    .EM_DETECT_OE_O(det_oe), .EM_PRESENT_O(pres),
    .EM_POWER_FAIL_N_I(pf_n), .PFAIL_TRIG_EN_I(pf_en),
    .BACKUP_TRIG_O(trig), .SMB_START_I(s_go), .SMB_ADDR_I(s_addr),
    .SMB_READ_I(s_rd), .SMB_WDATA_I(s_wd), .SMB_BUSY_O(s_busy),
    .SMB_DONE_O(s_done), .SMB_NACK_O(s_nack), .SMB_RDATA_O(s_rdata),
    .ENERGY_MODULE_SMB_CLOCK_O(scl), .ENERGY_MODULE_SMB_DATA_I(sda),
    .ENERGY_MODULE_SMB_DATA_O(sda_o), .ENERGY_MODULE_SMB_DATA_OE_O(sda_oe));

  nvsi_em_model #(.SLV_ADDR(EM_ADDR), .RD_BYTE(EM_BYTE)) i_em (
    .scl_i(scl), .sda_i(sda), .sda_oe_o(em_oe), .wr_byte_o(em_wr));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask : wr

  // Answer stands one cycle, so it is looked at right after the read edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    chk(16'(rvalid), 16'h0001);
    chk(16'(rdata), 16'(exp));
  endtask : rd

  task automatic count_lit(input int n);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      c += int'(act);
    end
  endtask : count_lit

  task automatic smb(input logic [6:0] a, input logic r, input logic [7:0] d);
    int k;
    k = 0;
    s_addr = a;
    s_rd = r;
    s_wd = d;
    s_go = 1'b1;
    @(negedge clk);
    s_go = 1'b0;
    while (s_done !== 1'b1 && k < 1000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 1000)
      bad_count++;
  endtask : smb

  task summarize;
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // Hang guard and trigger pulse tally
  always @(posedge clk) begin
    cycles++;
    trig_seen += int'(trig === 1'b1);
    if (cycles == 90000) begin
      bad_count++;
      summarize;
    end
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk(16'(pwr), 16'h0001);
    rd(USER_IND_OFFSET, USER_IND_RESET);
    wr(USER_IND_OFFSET, USER_IND_ON);
    rd(USER_IND_OFFSET, USER_IND_ON);
    chk(16'(usr), 16'h0001);
    wr(USER_IND_OFFSET, 8'h5A);
    rd(USER_IND_OFFSET, 8'h5A);
    chk(16'(usr), 16'h0000);
    wr(8'h11, USER_IND_ON);
    rd(8'h11, UNMAPPED_RDATA);
    wr(USER_IND_OFFSET, USER_IND_OFF);
    rd(USER_IND_OFFSET, USER_IND_OFF);
    count_lit(1200);
    chk(16'(c), 16'h0000);
    fw = 1'b1;
    count_lit(SLOW_PERIOD_MS * 4);
    chk(16'(c), 16'(SLOW_ON_MS * 4));
    bk = 1'b1;
    cyc(2);
    chk(16'(slowsel), 16'h0001);
    count_lit(FAST_PERIOD_MS * 4);
    chk(16'(c), 16'(FAST_ON_MS * 4));
    bk = 1'b0;
    rs = 1'b1;
    // One whole period: lit count does not depend on phase
    count_lit(FAST_PERIOD_MS * 4);
    chk(16'(c), 16'(FAST_ON_MS * 4));
    // End the operation while dark, so the slow restart is a fresh blink
    cyc(FAST_PERIOD_MS * 2);
    rs = 1'b0;
    em_here = 1'b1;
    cyc(3);
    chk(16'(pres), 16'h0001);
    em_here = 1'b0;
    cyc(3);
    chk(16'(pres), 16'h0000);
    dis = 1'b1;
    cyc(2);
    chk(16'(det), 16'h0000);
    chk(16'({det_oe, det_o}), 16'h0002);
    dis = 1'b0;
    pf_en = 1'b1;
    pf_n = 1'b0;
    cyc(4);
    chk(16'(trig_seen), 16'h0001);
    pf_n = 1'b1;
    pf_en = 1'b0;
    cyc(2);
    pf_n = 1'b0;
    cyc(4);
    chk(16'(trig_seen), 16'h0001);
    pf_n = 1'b1;
    smb(EM_ADDR, 1'b0, 8'hC3);
    chk(16'({s_nack, em_wr}), 16'h00C3);
    chk(16'({s_busy, sda_o}), 16'h0000);
    cyc(1);
    smb(EM_ADDR, 1'b1, 8'h00);
    chk(16'({s_nack, s_rdata}), 16'(EM_BYTE));
    cyc(1);
    smb(7'h22, 1'b0, 8'h11);
    chk(16'(s_nack), 16'h0001);
    summarize;
  end
endmodule : nvsi_tb_top
